// file: common/slcr_consts.vh
`ifndef SLCR_CONSTS_VH
`define SLCR_CONSTS_VH
`define SLCR_ADDR_ID 6'h00
`define SLCR_ADDR_ENABLE 6'h01
`define SLCR_ADDR_SDO 6'h02
`define SLCR_ADDR_REF 6'h03
`define SLCR_ADDR_PRESC 6'h04
`define SLCR_ADDR_PFD 6'h05
`define SLCR_ADDR_PFDDEL 6'h06
`define SLCR_ADDR_GAIN 6'h07
`define SLCR_ADDR_TRIM 6'h08
`define SLCR_ADDR_FORCE 6'h09
`define SLCR_ADDR_RSVA 6'h0A
`define SLCR_ADDR_RSVB 6'h0B
`define SLCR_ADDR_RSVC 6'h0C
`define SLCR_ADDR_RSVD 6'h0D
`define SLCR_ADDR_RSVE 6'h0E
`define SLCR_ADDR_INT 6'h0F
`define SLCR_ADDR_FRAC 6'h10
`define SLCR_ADDR_SEED 6'h11
`define SLCR_RST_ENABLE 24'h00FE9B
`define SLCR_RST_SDO 2'h3
`define SLCR_RST_REF 17'h08001
`define SLCR_RST_PRESC 1'h0
`define SLCR_RST_PFD 3'h6
`define SLCR_RST_PFDDEL 3'h2
`define SLCR_RST_GAIN 10'h210
`define SLCR_RST_TRIM 18'h20400
`define SLCR_RST_FORCE 2'h0
`define SLCR_RST_RSVA 24'h000304
`define SLCR_RST_RSVB 24'h000000
`define SLCR_RST_RSVC 24'h000100
`define SLCR_RST_RSVD 24'h000020
`define SLCR_RST_RSVE 24'h000000
`define SLCR_RST_INT 16'h00C8
`define SLCR_RST_FRAC 24'h000000
`define SLCR_RST_SEED 24'h000000
`define SLCR_CHIP_ID 24'h00A5C3
`define SLCR_FRAME_BITS 6'h20
`define SLCR_ADDR_LAST 6'h07
`define SLCR_REF_EN_BIT 2
`define SLCR_RATIO_MSB 13
`define SLCR_REF_SEL_BIT 14
`define SLCR_REF_AUTO_BIT 15
`define SLCR_REF_SINE_BIT 16
`endif

// file: dv/slcr_host.sv
`timescale 1ns/1ns
`default_nettype none
module slcr_host (
  // Serial clock and the shared device pin.
  input wire logic clk,
  input wire logic lock_or_serial_out_pin,
  // Frame select and data towards the device.
  output var logic serial_port_select,
  output var logic serial_in_pin
);
  // Idle host at time zero.
  initial begin
    serial_port_select = 1'b0;
    serial_in_pin = 1'b0;
  end
  // One frame of direction, address and data, MSB first; a short count aborts it early.
  // Read bits are taken at the falling edge, well away from the edge that launches them.
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [23:0] d,
      input int nbits, output logic [23:0] q);
    logic [31:0] word;
    word = {rw, a, d, 1'b0};
    q = 24'h000000;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      serial_port_select <= 1'b1;
      serial_in_pin <= word[31 - i];
      if (i >= 8 && i <= 31) begin
        @(negedge clk);
        q = {q[22:0], lock_or_serial_out_pin};
      end
    end
    @(posedge clk);
    serial_port_select <= 1'b0;
    // Nobody listens now, so the line must not keep showing the last bit.
    serial_in_pin <= ~serial_in_pin;
  endtask
endmodule // slcr_host
`default_nettype wire

// file: dv/slcr_props.sv
`timescale 1ns/1ns
`default_nettype none
module slcr_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched pins and controls.
  input wire logic serial_port_select,
  input wire logic lock_or_serial_out_oe,
  input wire logic [13:0] ref_divide_ratio,
  input wire logic ref_divider_used,
  input wire logic [23:0] enable_word,
  input wire logic [2:0] pfd_delay,
  input wire logic [4:0] pump_up_gain,
  input wire logic [3:0] pump_up_leak,
  input wire logic [1:0] pump_dummy_bias,
  input wire logic pump_force_up,
  input wire logic pump_force_down,
  input wire logic [15:0] integer_divide_value,
  input wire logic [23:0] fraction_divide_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reset values hold on the first edge after release, before any frame can land.
  a_ratio_at_reset: assert property ($rose(rst_b) |->
    ref_divide_ratio == 14'h0001 && !ref_divider_used) else $error("ratio reset wrong");
  a_pump_at_reset: assert property ($rose(rst_b) |->
    pump_up_gain == 5'h10 && pump_up_leak == 4'h4 && pump_dummy_bias == 2'h2)
    else $error("pump reset wrong");
  a_delay_at_reset: assert property ($rose(rst_b) |-> pfd_delay == 3'h2)
    else $error("delay reset wrong");
  a_word_at_reset: assert property ($rose(rst_b) |->
    integer_divide_value == 16'h00C8 && fraction_divide_value == 24'h000000)
    else $error("divide word reset wrong");
  // The pin is driven from the second edge after release onward.
  a_pin_driven: assert property ($past(rst_b) |-> lock_or_serial_out_oe)
    else $error("pin not driven");
  // Up and down forcing are two readings of one direction bit.
  a_force_one_way: assert property (!(pump_force_up && pump_force_down))
    else $error("pump forced both ways");
  // The divider flag and the enable word leave their registers on the same edge.
  a_div_needs_en: assert property (ref_divider_used |->
    enable_word[2]) else $error("divider used while held");
  // With select low for three edges no frame can be committing.
  a_idle_no_change: assert property (!serial_port_select [*3] |->
    $stable({ref_divide_ratio, pump_up_gain, integer_divide_value, fraction_divide_value}))
    else $error("control changed outside a frame");
  // Main scenarios.
  c_div_used: cover property (ref_divider_used);
  c_force_down: cover property (pump_force_down);
  c_long_frame: cover property (serial_port_select [*8]);
endmodule // slcr_props

bind slcr_regs slcr_props u_props (.clk, .rst_b, .serial_port_select, .lock_or_serial_out_oe,
  .ref_divide_ratio, .ref_divider_used, .enable_word, .pfd_delay, .pump_up_gain, .pump_up_leak,
  .pump_dummy_bias, .pump_force_up, .pump_force_down, .integer_divide_value,
  .fraction_divide_value);
`default_nettype wire

// file: dv/slcr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "slcr_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module slcr_regs_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lock_detect = 1'b0;
  logic [23:0] r;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  wire serial_port_select, serial_in_pin, lock_or_serial_out_pin, lock_or_serial_out_oe;
  wire ref_divider_used, ref_sine_select, prescaler_duty_mode, pfd_invert, pfd_up_gate;
  wire pfd_down_gate, pump_force_up, pump_force_down;
  wire [1:0] pump_dummy_bias;
  wire [2:0] pfd_delay;
  wire [3:0] pump_up_trim, pump_down_trim, pump_up_leak, pump_down_leak;
  wire [4:0] pump_up_gain, pump_down_gain;
  wire [13:0] ref_divide_ratio;
  wire [15:0] integer_divide_value;
  wire [23:0] enable_word, fraction_divide_value, modulator_start_seed;
  // Outputs regrouped in register bit order.
  wire [9:0] gain_word = {pump_down_gain, pump_up_gain};
  wire [17:0] trim_word = {pump_dummy_bias, pump_down_leak, pump_up_leak, pump_down_trim,
    pump_up_trim};
  wire [63:0] div_word = {integer_divide_value, fraction_divide_value, modulator_start_seed};
  // Map addresses with the value each holds when read back; the last one is unmapped.
  logic [5:0] addr_t [19] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h3F};
  logic [23:0] val_t [19] = '{`SLCR_CHIP_ID, 24'h00FE9B, 24'h000000, 24'h008001, 24'h000000,
    24'h000006, 24'h000002, 24'h000210, 24'h020400, 24'h000000, 24'h000304, 24'h000000,
    24'h000100, 24'h000020, 24'h000000, 24'h0000C8, 24'h000000, 24'h000000, 24'h000000};
  slcr_regs dut (.clk, .rst_b, .serial_port_select, .serial_in_pin, .lock_or_serial_out_pin,
    .lock_or_serial_out_oe, .lock_detect, .ref_divide_ratio, .ref_divider_used, .ref_sine_select,
    .enable_word, .prescaler_duty_mode, .pfd_invert, .pfd_up_gate, .pfd_down_gate, .pfd_delay,
    .pump_up_gain, .pump_down_gain, .pump_up_trim, .pump_down_trim, .pump_up_leak,
    .pump_down_leak, .pump_dummy_bias, .pump_force_up, .pump_force_down, .integer_divide_value,
    .fraction_divide_value, .modulator_start_seed);
  slcr_host host (.clk, .lock_or_serial_out_pin, .serial_port_select, .serial_in_pin);
  // Serial clock at 50 MHz.
  always #10 clk = ~clk;
  // The run needs about fifteen hundred cycles; a hang is cut off well beyond that.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      end_of_test();
    end
  end
  // A write frame, then a settled sample point once the registered outputs have moved.
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] q;
    host.xfer(1'b0, a, d, 32, q);
    @(posedge clk);
    @(negedge clk);
  endtask
  // A read frame compared with the expected word.
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] q;
    host.xfer(1'b1, a, 24'h000000, 32, q);
    `CHK(q, e);
  endtask
  // Single exit for both the normal end and the timeout.
  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK({ref_divide_ratio, ref_divider_used, ref_sine_select}, 16'h0004);
    `CHK(enable_word, 24'h00FE9B);
    `CHK({prescaler_duty_mode, pfd_delay}, 4'h2);
    `CHK({pfd_invert, pfd_up_gate, pfd_down_gate}, 3'h3);
    `CHK(gain_word, 10'h210);
    `CHK(trim_word, 18'h20400);
    `CHK({pump_force_down, pump_force_up}, 2'h0);
    `CHK(div_word, 64'h00C8000000000000);
    `CHK({lock_or_serial_out_oe, lock_or_serial_out_pin}, 2'h3);
    $display("test reset values done");
    @(posedge clk);
    lock_detect <= 1'b1;
    wr(6'h02, 24'h000002);
    `CHK(lock_or_serial_out_pin, 1'b0);
    wr(6'h02, 24'h000000);
    `CHK(lock_or_serial_out_pin, 1'b1);
    $display("test pin forcing done");
    for (int i = 0; i < 19; i++) rd(addr_t[i], val_t[i]);
    $display("test map readback done");
    wr(6'h07, 24'h0003E1);
    `CHK(gain_word, 10'h3E1);
    rd(6'h07, 24'h0003E1);
    wr(6'h08, 24'h01A5C3);
    `CHK(trim_word, 18'h1A5C3);
    wr(6'h05, 24'h000005);
    `CHK({pfd_down_gate, pfd_up_gate, pfd_invert}, 3'h5);
    wr(6'h06, 24'h000001);
    wr(6'h04, 24'h000001);
    `CHK({prescaler_duty_mode, pfd_delay}, 4'h9);
    wr(6'h0F, 24'h12ABCD);
    wr(6'h10, 24'h9C3A71);
    wr(6'h11, 24'h5E2B84);
    `CHK(div_word, 64'hABCD9C3A715E2B84);
    rd(6'h0F, 24'h00ABCD);
    wr(6'h00, 24'h123456);
    rd(6'h00, `SLCR_CHIP_ID);
    for (int v = 1; v < 4; v++) begin
      wr(6'h09, 24'(v));
      `CHK({pump_force_down, pump_force_up}, {v[1] & v[0], ~v[1] & v[0]});
    end
    $display("test field writes done");
    wr(6'h03, 24'h008005);
    `CHK({ref_divide_ratio, ref_divider_used}, 15'h000A);
    wr(6'h01, 24'h00FE9F);
    `CHK(ref_divider_used, 1'b1);
    wr(6'h03, 24'h008001);
    `CHK(ref_divider_used, 1'b0);
    wr(6'h03, 24'h004005);
    `CHK(ref_divider_used, 1'b1);
    wr(6'h03, 24'h000005);
    `CHK(ref_divider_used, 1'b0);
    wr(6'h01, 24'h00FF1F);
    wr(6'h03, 24'h017FFF);
    `CHK({ref_divide_ratio, ref_divider_used, ref_sine_select}, 16'hFFFF);
    $display("test reference path done");
    host.xfer(1'b0, 6'h0F, 24'h000777, 30, r);
    @(posedge clk);
    @(negedge clk);
    `CHK(integer_divide_value, 16'hABCD);
    wr(6'h0F, 24'h000777);
    `CHK(integer_divide_value, 16'h0777);
    $display("test aborted frame done");
    end_of_test();
  end
endmodule // slcr_regs_tb
`default_nettype wire

// file: hdl/slcr_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "slcr_consts.vh"

module slcr_regs (
  // Clock and reset; clk is the serial port clock.
  input wire clk,
  input wire rst_b,
  // Serial port pins.
  input wire serial_port_select,
  input wire serial_in_pin,
  output reg lock_or_serial_out_pin,
  output reg lock_or_serial_out_oe,
  // Lock detect level muxed onto the shared pin outside a read while no force is set.
  input wire lock_detect,
  // Reference path controls.
  output reg [13:0] ref_divide_ratio,
  output reg ref_divider_used,
  output reg ref_sine_select,
  output reg [23:0] enable_word,
  // Prescaler and phase detector controls.
  output reg prescaler_duty_mode,
  output reg pfd_invert,
  output reg pfd_up_gate,
  output reg pfd_down_gate,
  output reg [2:0] pfd_delay,
  // Charge pump controls.
  output reg [4:0] pump_up_gain,
  output reg [4:0] pump_down_gain,
  output reg [3:0] pump_up_trim,
  output reg [3:0] pump_down_trim,
  output reg [3:0] pump_up_leak,
  output reg [3:0] pump_down_leak,
  output reg [1:0] pump_dummy_bias,
  output reg pump_force_up,
  output reg pump_force_down,
  // Modulator words.
  output reg [15:0] integer_divide_value,
  output reg [23:0] fraction_divide_value,
  output reg [23:0] modulator_start_seed
);

  // Frame states; one-hot.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ADDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  reg [2:0] state_ff;
  reg [5:0] bit_cnt_ff;
  reg read_ff;
  reg [5:0] addr_ff;
  reg [23:0] shift_ff;
  reg [23:0] rd_shift_ff;
  reg [23:0] enable_ff;
  reg [1:0] sdo_force_ff;
  reg [16:0] ref_ff;
  reg presc_ff;
  reg [2:0] pfd_ff;
  reg [2:0] pfddel_ff;
  reg [9:0] gain_ff;
  reg [17:0] trim_ff;
  reg [1:0] force_ff;
  reg [23:0] rsva_ff;
  reg [23:0] rsvb_ff;
  reg [23:0] rsvc_ff;
  reg [23:0] rsvd_ff;
  reg [23:0] rsve_ff;
  reg [15:0] int_ff;
  reg [23:0] frac_ff;
  reg [23:0] seed_ff;
  reg [2:0] nxt_state;
  wire [23:0] wr_word;
  wire write_done;

  // Read-back mux; narrow registers sit low and unused bits read zero.
  function [23:0] read_mux;
    input [5:0] a;
    begin
      if (a == `SLCR_ADDR_ID) begin
        read_mux = `SLCR_CHIP_ID; // Identity value is arbitrary.
      end else if (a == `SLCR_ADDR_ENABLE) begin
        read_mux = enable_ff;
      end else if (a == `SLCR_ADDR_SDO) begin
        read_mux = {22'h000000, sdo_force_ff};
      end else if (a == `SLCR_ADDR_REF) begin
        read_mux = {7'h00, ref_ff};
      end else if (a == `SLCR_ADDR_PRESC) begin
        read_mux = {23'h000000, presc_ff};
      end else if (a == `SLCR_ADDR_PFD) begin
        read_mux = {21'h000000, pfd_ff};
      end else if (a == `SLCR_ADDR_PFDDEL) begin
        read_mux = {21'h000000, pfddel_ff};
      end else if (a == `SLCR_ADDR_GAIN) begin
        read_mux = {14'h0000, gain_ff};
      end else if (a == `SLCR_ADDR_TRIM) begin
        read_mux = {6'h00, trim_ff};
      end else if (a == `SLCR_ADDR_FORCE) begin
        read_mux = {22'h000000, force_ff};
      end else if (a == `SLCR_ADDR_RSVA) begin
        read_mux = rsva_ff;
      end else if (a == `SLCR_ADDR_RSVB) begin
        read_mux = rsvb_ff;
      end else if (a == `SLCR_ADDR_RSVC) begin
        read_mux = rsvc_ff;
      end else if (a == `SLCR_ADDR_RSVD) begin
        read_mux = rsvd_ff;
      end else if (a == `SLCR_ADDR_RSVE) begin
        read_mux = rsve_ff;
      end else if (a == `SLCR_ADDR_INT) begin
        read_mux = {8'h00, int_ff};
      end else if (a == `SLCR_ADDR_FRAC) begin
        read_mux = frac_ff;
      end else if (a == `SLCR_ADDR_SEED) begin
        read_mux = seed_ff;
      end else begin
        read_mux = 24'h000000;
      end
    end
  endfunction

  // Frame sequencer: one bit per rising edge while select is high.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (serial_port_select) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!serial_port_select) begin
          nxt_state = ST_IDLE;
        end else if (bit_cnt_ff == `SLCR_ADDR_LAST) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!serial_port_select || bit_cnt_ff == `SLCR_FRAME_BITS) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Data bits arrive on edges 8 to 31; the 32nd edge only completes the frame.
  // Committing the held word there keeps a stray bit on the data line out of it.
  assign wr_word = shift_ff;
  assign write_done = (state_ff == ST_DATA) && serial_port_select && !read_ff &&
                      (bit_cnt_ff == `SLCR_FRAME_BITS);

  // Shift machinery; bit_cnt_ff holds the frame number of the rising edge being taken.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 6'h00;
      read_ff <= 1'b0;
      addr_ff <= 6'h00;
      shift_ff <= 24'h000000;
      rd_shift_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) begin
        bit_cnt_ff <= 6'h02;
        read_ff <= serial_in_pin;
        addr_ff <= 6'h00;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
      if (state_ff == ST_ADDR) begin
        addr_ff <= {addr_ff[4:0], serial_in_pin};
      end
      if (state_ff == ST_DATA) begin
        shift_ff <= {shift_ff[22:0], serial_in_pin};
      end
      // Load the read word as the last address bit arrives, then shift MSB first.
      if (state_ff == ST_ADDR && bit_cnt_ff == `SLCR_ADDR_LAST) begin
        rd_shift_ff <= read_mux({addr_ff[4:0], serial_in_pin});
      end else if (state_ff == ST_DATA) begin
        rd_shift_ff <= {rd_shift_ff[22:0], 1'b0};
      end
    end
  end

  // Register file; a frame cut short never reaches write_done.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_ff <= `SLCR_RST_ENABLE;
      sdo_force_ff <= `SLCR_RST_SDO;
      ref_ff <= `SLCR_RST_REF;
      presc_ff <= `SLCR_RST_PRESC;
      pfd_ff <= `SLCR_RST_PFD;
      pfddel_ff <= `SLCR_RST_PFDDEL;
      gain_ff <= `SLCR_RST_GAIN;
      trim_ff <= `SLCR_RST_TRIM;
      force_ff <= `SLCR_RST_FORCE;
      rsva_ff <= `SLCR_RST_RSVA;
      rsvb_ff <= `SLCR_RST_RSVB;
      rsvc_ff <= `SLCR_RST_RSVC;
      rsvd_ff <= `SLCR_RST_RSVD;
      rsve_ff <= `SLCR_RST_RSVE;
      int_ff <= `SLCR_RST_INT;
      frac_ff <= `SLCR_RST_FRAC;
      seed_ff <= `SLCR_RST_SEED;
    end else if (write_done) begin
      if (addr_ff == `SLCR_ADDR_ENABLE) begin
        enable_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_SDO) begin
        sdo_force_ff <= wr_word[1:0];
      end else if (addr_ff == `SLCR_ADDR_REF) begin
        ref_ff <= wr_word[16:0];
      end else if (addr_ff == `SLCR_ADDR_PRESC) begin
        presc_ff <= wr_word[0];
      end else if (addr_ff == `SLCR_ADDR_PFD) begin
        pfd_ff <= wr_word[2:0];
      end else if (addr_ff == `SLCR_ADDR_PFDDEL) begin
        pfddel_ff <= wr_word[2:0];
      end else if (addr_ff == `SLCR_ADDR_GAIN) begin
        gain_ff <= wr_word[9:0];
      end else if (addr_ff == `SLCR_ADDR_TRIM) begin
        trim_ff <= wr_word[17:0];
      end else if (addr_ff == `SLCR_ADDR_FORCE) begin
        force_ff <= wr_word[1:0];
      end else if (addr_ff == `SLCR_ADDR_RSVA) begin
        rsva_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_RSVB) begin
        rsvb_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_RSVC) begin
        rsvc_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_RSVD) begin
        rsvd_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_RSVE) begin
        rsve_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_INT) begin
        int_ff <= wr_word[15:0];
      end else if (addr_ff == `SLCR_ADDR_FRAC) begin
        frac_ff <= wr_word;
      end else if (addr_ff == `SLCR_ADDR_SEED) begin
        seed_ff <= wr_word;
      end
    end
  end

  // Shared pin: force first, then read data while a read frame runs, else lock detect.
  // Read bits leave on rising edges 8 to 31, so the host takes each on the falling edge after.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_or_serial_out_pin <= 1'b0;
      lock_or_serial_out_oe <= 1'b0;
    end else begin
      if (sdo_force_ff[1]) begin
        lock_or_serial_out_pin <= sdo_force_ff[0];
      end else if (read_ff && state_ff == ST_DATA && nxt_state == ST_DATA) begin
        lock_or_serial_out_pin <= rd_shift_ff[23];
      end else begin
        lock_or_serial_out_pin <= lock_detect;
      end
      lock_or_serial_out_oe <= 1'b1;
    end
  end

  // Reference path controls; they follow the registers by one edge.
  // A zero ratio is the host's fault; the auto path then still uses the divider.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_divide_ratio <= 14'h0001;
      ref_divider_used <= 1'b0;
      ref_sine_select <= 1'b0;
      enable_word <= `SLCR_RST_ENABLE;
    end else begin
      ref_divide_ratio <= ref_ff[`SLCR_RATIO_MSB:0];
      if (!enable_ff[`SLCR_REF_EN_BIT]) begin
        ref_divider_used <= 1'b0;
      end else if (ref_ff[`SLCR_REF_AUTO_BIT]) begin
        ref_divider_used <= (ref_ff[`SLCR_RATIO_MSB:0] != 14'h0001);
      end else begin
        ref_divider_used <= ref_ff[`SLCR_REF_SEL_BIT];
      end
      ref_sine_select <= ref_ff[`SLCR_REF_SINE_BIT];
      enable_word <= enable_ff;
    end
  end

  // Prescaler and phase detector controls.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaler_duty_mode <= 1'b0;
      pfd_invert <= 1'b0;
      pfd_up_gate <= 1'b1;
      pfd_down_gate <= 1'b1;
      pfd_delay <= `SLCR_RST_PFDDEL;
    end else begin
      prescaler_duty_mode <= presc_ff;
      pfd_invert <= pfd_ff[0];
      pfd_up_gate <= pfd_ff[1];
      pfd_down_gate <= pfd_ff[2];
      pfd_delay <= pfddel_ff;
    end
  end

  // Charge pump controls; one direction bit feeds both forces, so they never rise together.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_up_gain <= 5'h10;
      pump_down_gain <= 5'h10;
      pump_up_trim <= 4'h0;
      pump_down_trim <= 4'h0;
      pump_up_leak <= 4'h4;
      pump_down_leak <= 4'h0;
      pump_dummy_bias <= 2'h2;
      pump_force_up <= 1'b0;
      pump_force_down <= 1'b0;
    end else begin
      pump_up_gain <= gain_ff[4:0];
      pump_down_gain <= gain_ff[9:5];
      pump_up_trim <= trim_ff[3:0];
      pump_down_trim <= trim_ff[7:4];
      pump_up_leak <= trim_ff[11:8];
      pump_down_leak <= trim_ff[15:12];
      pump_dummy_bias <= trim_ff[17:16];
      pump_force_up <= force_ff[0] & ~force_ff[1];
      pump_force_down <= force_ff[0] & force_ff[1];
    end
  end

  // Modulator words.
  // They move only after a complete frame has loaded the register behind them.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      integer_divide_value <= `SLCR_RST_INT;
      fraction_divide_value <= `SLCR_RST_FRAC;
      modulator_start_seed <= `SLCR_RST_SEED;
    end else begin
      integer_divide_value <= int_ff;
      fraction_divide_value <= frac_ff;
      modulator_start_seed <= seed_ff;
    end
  end

endmodule // slcr_regs

`default_nettype wire
